// file: common/dpm_defs.vh
/*
 * constants for the drive protection monitor: register offsets,
 * field positions, reset values and timing figures.
 * assumes a 50 MHz clock and a 10 ms protection time base.
 */
`ifndef DPM_DEFS_VH
`define DPM_DEFS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DPM_CLK_NS 20
`define DPM_TICK_NS 10000000
`define DPM_TICK_CYC (`DPM_TICK_NS / `DPM_CLK_NS)
`define DPM_TICK_MS 10
`define DPM_BRK_MAX_S 15
`define DPM_BRK_MAX_TICKS (`DPM_BRK_MAX_S * 1000 / `DPM_TICK_MS)
`define DPM_PCT 7'h64

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DPM_A_CTRL 6'h00
`define DPM_A_ULTIME 6'h04
`define DPM_A_LEVEL 6'h08
`define DPM_A_SPEED 6'h0c
`define DPM_A_DEV 6'h10
`define DPM_A_ENC 6'h14
`define DPM_A_FREQ 6'h18
`define DPM_A_DOUT 6'h1c
`define DPM_A_TRIP 6'h20
`define DPM_A_IRQST 6'h24
`define DPM_A_IRQMSK 6'h28
`define DPM_A_LIVE 6'h2c

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define DPM_C_VECTOR 0
`define DPM_C_DUTY 1
`define DPM_C_ULWEN 2
`define DPM_C_ULACT_LO 3
`define DPM_C_ULACT_HI 4
`define DPM_C_ESAVE 5
`define DPM_C_DEVEN 6
`define DPM_C_WIRE 7
`define DPM_C_FAN 8
`define DPM_CTRL_W 9
`define DPM_CTRL_RST 9'h0cc

// ----------------------------------------------------------------
// values and reset contents
// ----------------------------------------------------------------
`define DPM_ACT_FREE 2'h1
`define DPM_ACT_DEC 2'h2
`define DPM_FN_UL 8'h06
`define DPM_FN_FAN 8'h08
`define DPM_FN_DBW 8'h1f
`define DPM_ULTIME_RST 32'h0bb8_03e8
`define DPM_LEVEL_RST 24'h0a_1e_1e
`define DPM_SPEED_RST 32'h0001_2ee0
`define DPM_DEV_RST 32'h0064_07d0
`define DPM_ENC_RST 16'h0064
`define DPM_FREQ_RST 32'h1770_00c8
`define DPM_DOUT_RST 24'h00_00_00

// ----------------------------------------------------------------
// trip and event bit positions
// ----------------------------------------------------------------
`define DPM_T_ULFREE 0
`define DPM_T_ULDEC 1
`define DPM_T_OVS 2
`define DPM_T_DEV 3
`define DPM_T_ENC 4
`define DPM_T_FAN 5
`define DPM_NTRIP 6
`define DPM_NEV 8

`endif

// file: hw/dpm_persist.v
/*
 * persistence timer: raises its hit flag once a condition has held
 * for a set number of time-base ticks.
 * assumes a one-cycle tick strobe on the same clock.
 */
`timescale 1ns/1ns
module dpm_persist #(
    parameter W = 16
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_tick,
    input wire i_cond,
    input wire [W-1:0] i_limit,
    output reg o_hit
);

reg [W-1:0] cnt_q;

// ----------------------------------------------------------------
// counter
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        cnt_q <= {W{1'b0}};
        o_hit <= 1'b0;
    end else if (!i_cond) begin
        cnt_q <= {W{1'b0}};
        o_hit <= 1'b0;
    end else begin
        if (cnt_q >= i_limit) begin
            o_hit <= 1'b1;
        end else if (i_tick) begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule

// file: hw/dpm_monitor.v
/*
 * drive protection monitor: braking resistor supervision, underload,
 * overspeed and speed deviation (vector mode only), encoder wire and fan fault protection,
 * with an ahb-lite register slave and one level interrupt.
 * assumes drive measurements arrive on i_clk; encoder and fan pins
 * are asynchronous and are synchronised here.
 */
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "dpm_defs.vh"
module dpm_monitor #(
    parameter P_TICK_CYC = `DPM_TICK_CYC
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    input wire i_running,
    input wire i_decel,
    input wire i_cycle_end,
    input wire i_brake_req,
    input wire [7:0] i_out_current,
    input wire [15:0] i_out_freq,
    input wire [15:0] i_motor_speed,
    input wire [15:0] i_speed_ref,
    input wire i_enc_fitted,
    input wire i_enc_wire_ok,
    input wire i_fan_err,
    output reg o_output_block,
    output reg o_decel_stop,
    output reg o_brake_drive,
    output reg [2:0] o_dout,
    output reg o_irq
);

localparam [31:0] TICK_LAST_W = P_TICK_CYC - 1;
localparam [19:0] TICK_LAST = TICK_LAST_W[19:0];
localparam [31:0] BRK_LIMIT_W = `DPM_BRK_MAX_TICKS;
localparam [15:0] BRK_LIMIT = BRK_LIMIT_W[15:0];

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [`DPM_CTRL_W-1:0] ctrl_q;
reg [31:0] ultime_q;
reg [23:0] level_q;
reg [31:0] speed_q;
reg [31:0] dev_q;
reg [15:0] enc_q;
reg [31:0] freq_q;
reg [23:0] dout_q;
reg [`DPM_NTRIP-1:0] trip_q;
reg [`DPM_NEV-1:0] irqst_q;
reg [`DPM_NEV-1:0] irqmsk_q;
reg [`DPM_NEV-1:0] lvl_prev_q;
reg [19:0] tick_cnt_q;
reg tick_q;
reg [2:0] sync1_q;
reg [2:0] sync2_q;
reg [19:0] dec_cnt_q;
reg [19:0] tot_cnt_q;
reg db_warn_q;
reg wr_pend_q;
reg [5:0] wr_addr_q;

wire vector = ctrl_q[`DPM_C_VECTOR];
wire heavy = ctrl_q[`DPM_C_DUTY];
wire [1:0] ul_act = ctrl_q[`DPM_C_ULACT_HI:`DPM_C_ULACT_LO];
wire fan_warn_mode = ctrl_q[`DPM_C_FAN];
wire enc_fit_s = sync2_q[0];
wire enc_ok_s = sync2_q[1];
wire fan_err_s = sync2_q[2];

// ----------------------------------------------------------------
// pin synchronisers and time base
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        sync1_q <= 3'h0;
        sync2_q <= 3'h0;
        tick_cnt_q <= 20'h0;
        tick_q <= 1'b0;
    end else begin
        sync1_q <= {i_fan_err, i_enc_wire_ok, i_enc_fitted};
        sync2_q <= sync1_q;
        tick_q <= (tick_cnt_q == TICK_LAST);
        if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= 20'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 20'h1;
        end
    end
end

// ----------------------------------------------------------------
// underload detection
// ----------------------------------------------------------------
wire [15:0] f_slip = freq_q[15:0];
wire [15:0] f_base = freq_q[31:16];
wire [7:0] lf_lvl = level_q[7:0];
wire [7:0] bf_lvl = level_q[15:8];
wire [15:0] span = f_base - f_slip;
wire [15:0] pos = i_out_freq - f_slip;
wire [23:0] lhs_u = i_out_current * span;
wire [23:0] lf_u = lf_lvl * span;
wire signed [9:0] dlev = $signed({2'b00, bf_lvl}) - $signed({2'b00, lf_lvl});
wire signed [26:0] slope = dlev * $signed({1'b0, pos});
wire signed [26:0] rhs = $signed({3'b000, lf_u}) + slope;
wire in_band = (i_out_freq >= f_slip);
wire at_base = (i_out_freq >= f_base) || (f_base <= f_slip);
wire ul_low = !in_band ? 1'b0 :
              (at_base || heavy) ? (i_out_current < bf_lvl) :
              ($signed({3'b000, lhs_u}) < rhs);
wire ul_cond = i_running && ul_low && !ctrl_q[`DPM_C_ESAVE];

wire ul_warn_hit;
wire ul_trip_hit;
wire ovs_hit;
wire dev_hit;
wire enc_hit;
wire brk_hit;

dpm_persist #(.W(16)) u_ulwarn (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(tick_q),
    .i_cond(ul_cond),
    .i_limit(ultime_q[15:0]),
    .o_hit(ul_warn_hit)
);

dpm_persist #(.W(16)) u_ultrip (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(tick_q),
    .i_cond(ul_cond),
    .i_limit(ultime_q[31:16]),
    .o_hit(ul_trip_hit)
);

// ----------------------------------------------------------------
// speed and encoder protection
// ----------------------------------------------------------------
wire [15:0] dev_abs = (i_motor_speed >= i_speed_ref) ?
                      (i_motor_speed - i_speed_ref) :
                      (i_speed_ref - i_motor_speed);
wire ovs_cond = vector && (i_motor_speed > speed_q[15:0]);
wire dev_cond = vector && ctrl_q[`DPM_C_DEVEN] && (dev_abs > dev_q[15:0]);
wire enc_cond = enc_fit_s && ctrl_q[`DPM_C_WIRE] && !enc_ok_s;

dpm_persist #(.W(16)) u_ovs (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(tick_q),
    .i_cond(ovs_cond),
    .i_limit(speed_q[31:16]),
    .o_hit(ovs_hit)
);

dpm_persist #(.W(16)) u_dev (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(tick_q),
    .i_cond(dev_cond),
    .i_limit(dev_q[31:16]),
    .o_hit(dev_hit)
);

dpm_persist #(.W(16)) u_enc (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(tick_q),
    .i_cond(enc_cond),
    .i_limit(enc_q),
    .o_hit(enc_hit)
);

// ----------------------------------------------------------------
// braking resistor supervision
// ----------------------------------------------------------------
// continuous braking cap
dpm_persist #(.W(16)) u_brk (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_tick(tick_q),
    .i_cond(i_brake_req),
    .i_limit(BRK_LIMIT),
    .o_hit(brk_hit)
);

wire [26:0] dec_pct = dec_cnt_q * `DPM_PCT;
wire [27:0] lvl_tot = level_q[23:16] * tot_cnt_q;

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        dec_cnt_q <= 20'h0;
        tot_cnt_q <= 20'h0;
        db_warn_q <= 1'b0;
    end else if (i_cycle_end) begin
        db_warn_q <= ({1'b0, dec_pct} > lvl_tot);
        dec_cnt_q <= 20'h0;
        tot_cnt_q <= 20'h0;
    end else if (tick_q && (tot_cnt_q != 20'hfffff)) begin
        tot_cnt_q <= tot_cnt_q + 20'h1;
        if (i_decel) begin
            dec_cnt_q <= dec_cnt_q + 20'h1;
        end
    end
end

// ----------------------------------------------------------------
// trips, events and outputs
// ----------------------------------------------------------------
wire [`DPM_NTRIP-1:0] trip_set;
assign trip_set[`DPM_T_ULFREE] = ul_trip_hit && (ul_act == `DPM_ACT_FREE);
assign trip_set[`DPM_T_ULDEC] = ul_trip_hit && (ul_act == `DPM_ACT_DEC);
assign trip_set[`DPM_T_OVS] = ovs_hit;
assign trip_set[`DPM_T_DEV] = dev_hit;
assign trip_set[`DPM_T_ENC] = enc_hit;
assign trip_set[`DPM_T_FAN] = fan_err_s && !fan_warn_mode;

wire [`DPM_NEV-1:0] lvl = {brk_hit, db_warn_q, fan_err_s, enc_hit,
                            dev_hit, ovs_hit, ul_trip_hit, ul_warn_hit};
wire [`DPM_NEV-1:0] ev = lvl & ~lvl_prev_q;
wire ul_warn_on = ul_warn_hit && ctrl_q[`DPM_C_ULWEN];
wire fan_warn_on = fan_err_s && fan_warn_mode;

wire wr_go = wr_pend_q;
wire [`DPM_NTRIP-1:0] trip_clr = (wr_go && wr_addr_q == `DPM_A_TRIP) ?
                                 i_hwdata[`DPM_NTRIP-1:0] : 6'h00;
wire [`DPM_NEV-1:0] irq_clr = (wr_go && wr_addr_q == `DPM_A_IRQST) ?
                              i_hwdata[`DPM_NEV-1:0] : 8'h00;
wire [`DPM_NTRIP-1:0] trip_d = (trip_q & ~trip_clr) | trip_set;
wire [`DPM_NEV-1:0] irqst_d = (irqst_q & ~irq_clr) | ev;

function dout_bit;
    input [7:0] fn;
    input ulw;
    input fanw;
    input dbw;
    begin
        dout_bit = ((fn == `DPM_FN_UL) && ulw) ||
                   ((fn == `DPM_FN_FAN) && fanw) ||
                   ((fn == `DPM_FN_DBW) && dbw);
    end
endfunction

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        trip_q <= 6'h00;
        irqst_q <= 8'h00;
        lvl_prev_q <= 8'h00;
        o_output_block <= 1'b0;
        o_decel_stop <= 1'b0;
        o_brake_drive <= 1'b0;
        o_dout <= 3'h0;
        o_irq <= 1'b0;
    end else begin
        // set wins over clear
        trip_q <= trip_d;
        irqst_q <= irqst_d;
        lvl_prev_q <= lvl;
        o_output_block <= trip_d[`DPM_T_ULFREE] | trip_d[`DPM_T_OVS] |
                          trip_d[`DPM_T_DEV] | trip_d[`DPM_T_ENC] |
                          trip_d[`DPM_T_FAN];
        o_decel_stop <= trip_d[`DPM_T_ULDEC];
        o_brake_drive <= i_brake_req && !brk_hit;
        o_dout[0] <= dout_bit(dout_q[7:0], ul_warn_on, fan_warn_on,
                              db_warn_q);
        o_dout[1] <= dout_bit(dout_q[15:8], ul_warn_on, fan_warn_on,
                              db_warn_q);
        o_dout[2] <= dout_bit(dout_q[23:16], ul_warn_on, fan_warn_on,
                              db_warn_q);
        o_irq <= |(irqst_d & irqmsk_q);
    end
end

// ----------------------------------------------------------------
// ahb-lite slave
// ----------------------------------------------------------------
wire addr_ok = i_hsel && i_hready && i_htrans[1];
wire [5:0] a = i_haddr[5:0];
wire [31:0] live = {22'h0, fan_warn_on, db_warn_q, brk_hit, enc_hit,
                    dev_hit, ovs_hit, ul_trip_hit, ul_warn_hit, ul_cond};
reg [31:0] rd_d;

always @* begin
    rd_d = 32'h0;
    case (a)
        `DPM_A_CTRL: rd_d = {23'h0, ctrl_q};
        `DPM_A_ULTIME: rd_d = ultime_q;
        `DPM_A_LEVEL: rd_d = {8'h0, level_q};
        `DPM_A_SPEED: rd_d = speed_q;
        `DPM_A_DEV: rd_d = dev_q;
        `DPM_A_ENC: rd_d = {16'h0, enc_q};
        `DPM_A_FREQ: rd_d = freq_q;
        `DPM_A_DOUT: rd_d = {8'h0, dout_q};
        `DPM_A_TRIP: rd_d = {26'h0, trip_q};
        `DPM_A_IRQST: rd_d = {24'h0, irqst_q};
        `DPM_A_IRQMSK: rd_d = {24'h0, irqmsk_q};
        `DPM_A_LIVE: rd_d = live;
        default: rd_d = 32'h0;
    endcase
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_hrdata <= 32'h0;
        o_hreadyout <= 1'b1;
        o_hresp <= 1'b0;
        wr_pend_q <= 1'b0;
        wr_addr_q <= 6'h00;
        ctrl_q <= `DPM_CTRL_RST;
        ultime_q <= `DPM_ULTIME_RST;
        level_q <= `DPM_LEVEL_RST;
        speed_q <= `DPM_SPEED_RST;
        dev_q <= `DPM_DEV_RST;
        enc_q <= `DPM_ENC_RST;
        freq_q <= `DPM_FREQ_RST;
        dout_q <= `DPM_DOUT_RST;
        irqmsk_q <= 8'h00;
    end else begin
        o_hreadyout <= 1'b1;
        o_hresp <= 1'b0;
        wr_pend_q <= addr_ok && i_hwrite;
        wr_addr_q <= a;
        if (addr_ok && !i_hwrite) begin
            o_hrdata <= rd_d;
        end
        if (wr_go) begin
            case (wr_addr_q)
                `DPM_A_CTRL: ctrl_q <= i_hwdata[`DPM_CTRL_W-1:0];
                `DPM_A_ULTIME: ultime_q <= i_hwdata;
                `DPM_A_LEVEL: level_q <= i_hwdata[23:0];
                `DPM_A_SPEED: speed_q <= i_hwdata;
                `DPM_A_DEV: dev_q <= i_hwdata;
                `DPM_A_ENC: enc_q <= i_hwdata[15:0];
                `DPM_A_FREQ: freq_q <= i_hwdata;
                `DPM_A_DOUT: dout_q <= i_hwdata[23:0];
                `DPM_A_IRQMSK: irqmsk_q <= i_hwdata[`DPM_NEV-1:0];
                default: irqmsk_q <= irqmsk_q;
            endcase
        end
    end
end

endmodule

// file: verif/dpm_monitor_props.sv
/* port checker for the drive protection monitor.
   assumes a bind onto dpm_monitor and a single clock domain. */
`timescale 1ns/1ns
`include "dpm_defs.vh"
module dpm_monitor_props #(
    parameter P_TICK_CYC = `DPM_TICK_CYC
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire i_hready,
    input wire [31:0] o_hrdata,
    input wire o_hreadyout,
    input wire o_hresp,
    input wire i_brake_req,
    input wire o_output_block,
    input wire o_decel_stop,
    input wire o_brake_drive,
    input wire o_irq
);
    localparam int LIM = (`DPM_BRK_MAX_TICKS + 2) * P_TICK_CYC;
    wire wr = i_hsel && i_hready && i_htrans[1] && i_hwrite;
    wire rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
    wire unmapped = i_haddr[31:6] == 26'h0 && i_haddr[5:0] >= 6'h30;
    int brk_q;
    logic wrote_q;
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            brk_q <= 0;
            wrote_q <= 1'b0;
        end else begin
            brk_q <= o_brake_drive ? brk_q + 1 : 0;
            wrote_q <= wrote_q | wr;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_zero_wait: assert property (o_hreadyout && !o_hresp)
        else $error("slave stalled or answered with an error");
    a_unmapped_zero: assert property (rd && unmapped |=> o_hrdata == 0)
        else $error("unmapped read returned data");
    a_irq_quiet: assert property (!wrote_q |-> !o_irq)
        else $error("interrupt raised with no mask written");
    a_brake_start: assert property ($rose(i_brake_req)
        |=> o_brake_drive)
        else $error("brake drive did not follow request");
    a_brake_off: assert property (!i_brake_req |=> !o_brake_drive)
        else $error("brake drive without request");
    a_brake_limit: assert property (brk_q <= LIM)
        else $error("brake interval too long");
    a_brake_held_off: assert property (i_brake_req &&
        $past(i_brake_req) && !o_brake_drive |=> !o_brake_drive)
        else $error("brake drive resumed without new request");
    a_block_latch: assert property (o_output_block && !$past(wr)
        |=> o_output_block)
        else $error("output block released without software");
    a_decel_latch: assert property (o_decel_stop && !$past(wr)
        |=> o_decel_stop)
        else $error("decel stop released without software");
    c_brake_cut: cover property (i_brake_req && $fell(o_brake_drive));
    c_block: cover property ($rose(o_output_block));
    c_decel: cover property ($rose(o_decel_stop));
    c_irq: cover property ($rose(o_irq));
endmodule

// file: verif/dpm_plant.sv
/* model of motor, braking resistor, encoder and cooling fan.
   assumes commands from the bench on the monitor's clock. */
`timescale 1ns/1ns
module dpm_plant (
    input wire i_clk,
    input wire i_nrst,
    input wire [7:0] i_load,
    input wire [15:0] i_spd,
    input wire i_brk,
    input wire i_fan,
    input wire i_cut,
    input wire i_blk,
    input wire i_stop,
    output reg o_running,
    output reg o_decel,
    output reg o_cycle_end,
    output reg o_brake_req,
    output reg [7:0] o_current,
    output reg [15:0] o_speed,
    output reg o_wire_ok,
    output reg o_fan_err
);
    reg [5:0] cyc_q;
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cyc_q <= 6'h0;
            o_running <= 1'b0;
            o_decel <= 1'b0;
            o_cycle_end <= 1'b0;
            o_brake_req <= 1'b0;
            o_current <= 8'h0;
            o_speed <= 16'h0;
            o_wire_ok <= 1'b1;
            o_fan_err <= 1'b0;
        end else begin
            cyc_q <= cyc_q + 6'h1;
            // motor coasts once output is blocked and decelerates once stopped
            o_running <= !i_blk && !i_stop;
            o_decel <= i_stop;
            o_cycle_end <= cyc_q == 6'h3f;
            o_brake_req <= i_brk;
            o_current <= o_running ? i_load : 8'h0;
            o_speed <= i_spd;
            // a cut line-drive pair reads as a lost wire
            o_wire_ok <= !i_cut;
            o_fan_err <= i_fan;
        end
    end
endmodule

// file: verif/dpm_monitor_bench.sv
/* self-checking bench for the drive protection monitor.
   assumes dpm_plant on the drive side and a 10-cycle time base. */
`timescale 1ns/1ns
`include "dpm_defs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module dpm_monitor_bench;
    localparam int TK = 10;
    logic i_clk = 0, i_nrst = 0, hsel = 0, hwrite = 0;
    logic brk = 0, fan = 0, cut = 0;
    logic [31:0] haddr = 0, hwdata = 0, rng = 32'h7822;
    logic [1:0] htrans = 0;
    logic [7:0] load = 8'd50;
    logic [15:0] spd = 16'd6000, ofrq = 16'd6000;
    logic [31:0] ctab [4] = '{32'h8c, 32'h8d, 32'hcd, 32'h8d};
    logic [15:0] stab [4] = '{16'd12001, 16'd12001, 16'd8001, 16'd8001};
    logic etab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wire [31:0] hrdata;
    wire [15:0] mspd;
    wire [7:0] cur;
    wire [2:0] dout;
    wire hready, hresp, blk, stop, bdrv, irq, run, dec, cend, breq, wok, ferr;
    int n_mismatch = 0, n_tests = 0;
    always #10 i_clk = ~i_clk;
    dpm_monitor #(.P_TICK_CYC(TK)) dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_running(run),
        .i_decel(dec), .i_cycle_end(cend), .i_brake_req(breq),
        .i_out_current(cur), .i_out_freq(ofrq), .i_motor_speed(mspd),
        .i_speed_ref(16'd6000), .i_enc_fitted(1'b1), .i_enc_wire_ok(wok),
        .i_fan_err(ferr), .o_output_block(blk), .o_decel_stop(stop),
        .o_brake_drive(bdrv), .o_dout(dout), .o_irq(irq));
    dpm_plant plant (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_load(load), .i_spd(spd),
        .i_brk(brk), .i_fan(fan), .i_cut(cut), .i_blk(blk), .i_stop(stop),
        .o_running(run), .o_decel(dec), .o_cycle_end(cend),
        .o_brake_req(breq), .o_current(cur), .o_speed(mspd),
        .o_wire_ok(wok), .o_fan_err(ferr));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge i_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge i_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [31:0] a, e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        `CHK(r, e)
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic rst();
        @(posedge i_clk);
        i_nrst <= 1'b0;
        brk <= 1'b0;
        fan <= 1'b0;
        cut <= 1'b0;
        load <= 8'd50;
        spd <= 16'd6000;
        ofrq <= 16'd6000;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
    endtask
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #800000;
        n_mismatch++;
        print_verdict();
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        int i;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        rdc(`DPM_A_CTRL, 32'h0cc);
        rdc(`DPM_A_ULTIME, `DPM_ULTIME_RST);
        rdc(`DPM_A_IRQMSK, 32'h0);
        rdc(32'h30, 32'h0);
        wr(`DPM_A_IRQMSK, 32'h80);
        @(posedge i_clk);
        brk <= 1'b1;
        wt(14800);
        `CHK(bdrv, 1'b1)
        `CHK(irq, 1'b0)
        wt(400);
        `CHK(bdrv, 1'b0)
        `CHK(irq, 1'b1)
        wr(`DPM_A_IRQMSK, 32'h0);
        wt(2);
        `CHK(irq, 1'b0)
        wr(`DPM_A_IRQST, 32'h80);
        wr(`DPM_A_IRQMSK, 32'h80);
        wt(2);
        `CHK(irq, 1'b0)
        rst();
        wr(`DPM_A_ULTIME, {16'd20, 16'd5});
        wr(`DPM_A_DOUT, 32'h0606);
        rng = xs(rng);
        @(posedge i_clk);
        load <= rng[7:0] % 8'd28 + 8'd1;
        wt(150);
        `CHK(dout[1:0], 2'h3)
        @(posedge i_clk);
        load <= 8'd80;
        wt(30);
        `CHK(dout[1:0], 2'h0)
        rng = xs(rng);
        @(posedge i_clk);
        load <= rng[7:0] % 8'd28 + 8'd1;
        wt(30);
        `CHK(dout[0], 1'b0)
        wt(120);
        `CHK(blk, 1'b0)
        wt(120);
        `CHK(blk, 1'b1)
        `CHK(stop, 1'b0)
        for (i = 0; i < 2; i++) begin
            rst();
            wr(`DPM_A_CTRL, i ? 32'hf4 : 32'hd4);
            wr(`DPM_A_ULTIME, {16'd5, 16'd5});
            wr(`DPM_A_DOUT, 32'h1f_0000);
            @(posedge i_clk);
            load <= 8'd10;
            wt(120);
            `CHK(stop, i == 0)
            `CHK(blk, 1'b0)
            wt(100);
            `CHK(dout[2], i == 0)
        end
        // normal-duty curve and heavy-duty flat level between slip and base points
        for (i = 0; i < 2; i++) begin
            rst();
            @(posedge i_clk);
            ofrq <= 16'd780;
            load <= 8'd40;
            wr(`DPM_A_CTRL, i ? 32'hce : 32'hcc);
            wr(`DPM_A_ULTIME, {16'd6, 16'd6});
            wr(`DPM_A_LEVEL, 32'h0a_64_0a);
            wt(120);
            `CHK(blk, i == 1)
        end
        for (i = 0; i < 4; i++) begin
            rst();
            wr(`DPM_A_DEV, {16'd5, 16'd2000});
            wr(`DPM_A_CTRL, ctab[i]);
            @(posedge i_clk);
            spd <= stab[i];
            wt(100);
            `CHK(blk, etab[i])
        end
        rst();
        wr(`DPM_A_ENC, 32'd5);
        @(posedge i_clk);
        cut <= 1'b1;
        wt(30);
        `CHK(blk, 1'b0)
        wt(50);
        `CHK(blk, 1'b1)
        for (i = 0; i < 2; i++) begin
            rst();
            wr(`DPM_A_CTRL, i ? 32'h1cc : 32'h0cc);
            wr(`DPM_A_DOUT, 32'h08_0000);
            @(posedge i_clk);
            fan <= 1'b1;
            wt(10);
            `CHK(blk, i == 0)
            `CHK(dout[2], i == 1)
        end
        print_verdict();
    end
endmodule
bind dpm_monitor dpm_monitor_props #(.P_TICK_CYC(P_TICK_CYC)) u_props (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_brake_req(i_brake_req), .o_output_block(o_output_block),
    .o_decel_stop(o_decel_stop), .o_brake_drive(o_brake_drive),
    .o_irq(o_irq));
